// >>> core/srp_pkg.sv
package srp_pkg;
   // ============================================================
   // Register map
   localparam logic [7:0] REG_SER_DRV = 8'h54;
   localparam logic [7:0] REG_PULSE_GEN = 8'h5a;
   localparam logic [7:0] REG_SYNC_IN = 8'h5b;
   localparam logic [7:0] REG_TIMER_LO = 8'h5c;
   localparam logic [7:0] REG_TIMER_HI = 8'h5d;
   localparam logic [7:0] REG_CLK_IN = 8'h64;
   localparam logic [7:0] REG_DLY_COMMON = 8'h65;
   // ============================================================
   // Field positions and reset values
   localparam int DRV_EN_BIT = 0;
   localparam int DRV_PP_BIT = 1;
   localparam int SYNC_POL_BIT = 0;
   localparam int SYNC_RETIME_BIT = 2;
   localparam int CLK_DIV2_BIT = 1;
   localparam logic [7:0] RST_SER_DRV = 8'h00;
   localparam logic [7:0] RST_PULSE_GEN = 8'h00;
   localparam logic [7:0] RST_SYNC_IN = 8'h00;
   localparam logic [7:0] RST_TIMER_LO = 8'h00;
   localparam logic [7:0] RST_TIMER_HI = 8'h00;
   localparam logic [7:0] RST_CLK_IN = 8'h00;
   localparam logic [7:0] RST_DLY_COMMON = 8'h00;
   localparam logic [7:0] MASK_SER_DRV = 8'h03;
   localparam logic [7:0] MASK_PULSE_GEN = 8'h07;
   localparam logic [7:0] MASK_SYNC_IN = 8'h05;
   localparam logic [7:0] MASK_TIMER_HI = 8'h0f;
   localparam logic [7:0] MASK_CLK_IN = 8'h03;
   localparam logic [7:0] MASK_DLY_COMMON = 8'h01;
   // ============================================================
   // Pulse generator modes
   typedef enum logic [2:0]
   {
      PM_LEVEL = 3'h0,
      PM_ONE = 3'h1,
      PM_TWO = 3'h2,
      PM_FOUR = 3'h3,
      PM_EIGHT = 3'h4,
      PM_SIXTEEN = 3'h5,
      PM_SIXTEEN_B = 3'h6,
      PM_CONT = 3'h7
   } srp_mode_e;
   localparam int GIN_SEL_PULSE_REQ = 4;
   localparam logic [2:0] GIN_SEL_PULSE = 3'h4;
endpackage

// >>> core/srp_cfg_if.sv
`timescale 1ns/1ps
// Configuration carried from the register bank to the pulse engine.
interface srp_cfg_if;
   logic [2:0] mode;
   logic [11:0] setpoint;
   logic request;
   logic sysref;
   logic busy;
   modport bank (output mode, output setpoint, output request,
      input sysref, input busy);
   modport engine (input mode, input setpoint, input request,
      output sysref, output busy);
endinterface

// >>> core/srp_pulse_engine.sv
`timescale 1ns/1ps
module srp_pulse_engine
(
   input wire logic clk_i,  // System clock
   input wire logic srst_i, // Synchronous reset
   srp_cfg_if.engine cfg    // Configuration and output
);
   import srp_pkg::*;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_DONE = 2'h2
   } srp_state_e;

   // ============================================================
   // Master timer beat
   logic [11:0] beat_cnt_reg;
   logic beat;
   assign beat = (beat_cnt_reg == 12'h000);
   always_ff @(posedge clk_i)
   begin
      if (srst_i || beat)
         beat_cnt_reg <= cfg.setpoint;
      else
         beat_cnt_reg <= beat_cnt_reg - 12'h001;
   end

   // ============================================================
   // Burst sequencing
   srp_state_e state_reg, state_next;
   logic sysref_reg;
   logic [5:0] edge_cnt_reg;
   logic [5:0] burst_edges;
   logic is_level, is_cont, is_burst, run_req, last_edge;
   srp_mode_e mode;
   assign mode = srp_mode_e'(cfg.mode);
   assign is_level = (mode == PM_LEVEL);
   assign is_cont = (mode == PM_CONT);
   assign is_burst = !is_level && !is_cont;
   // Two toggles per pulse; codes 5 and 6 both give sixteen pulses.
   assign burst_edges = (mode == PM_ONE) ? 6'h02 :
                        (mode == PM_TWO) ? 6'h04 :
                        (mode == PM_FOUR) ? 6'h08 :
                        (mode == PM_EIGHT) ? 6'h10 : 6'h20;
   // A mode change in mid-burst must not let the count run past its end.
   assign last_edge = (edge_cnt_reg >= burst_edges - 6'h01);
   assign run_req = is_cont || cfg.request;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:
            if (run_req)
               state_next = ST_RUN;
         ST_RUN:
            if (is_level && !cfg.request && !sysref_reg)
               state_next = ST_IDLE;
            else if (is_burst && beat && last_edge)
               state_next = ST_DONE;
         ST_DONE:
            if (!cfg.request)
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_reg <= ST_IDLE;
         sysref_reg <= 1'b0;
         edge_cnt_reg <= 6'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == ST_RUN && beat && state_next == ST_RUN)
         begin
            sysref_reg <= ~sysref_reg;
            // Only bursts count, so a later burst starts from zero.
            edge_cnt_reg <= is_burst ? edge_cnt_reg + 6'h01 : 6'h00;
         end
         else if (state_next != ST_RUN)
         begin
            sysref_reg <= 1'b0;
            edge_cnt_reg <= 6'h00;
         end
      end
   end

   assign cfg.sysref = sysref_reg;
   assign cfg.busy = (state_reg == ST_RUN);

   // ============================================================
   // Checks
   burst_stop_a: assert property (
      @(posedge clk_i) disable iff (srst_i)
      state_reg == ST_DONE |-> !sysref_reg)
      else $error("Output high after burst end.");
   level_stop_a: assert property (
      @(posedge clk_i) disable iff (srst_i)
      is_level && !cfg.request && !sysref_reg && state_reg == ST_RUN
      |=> state_reg == ST_IDLE)
      else $error("Level mode did not stop.");
   edge_bound_a: assert property (
      @(posedge clk_i) disable iff (srst_i)
      is_burst |-> edge_cnt_reg <= burst_edges)
      else $error("Burst exceeded its edge count.");
   toggle_beat_a: assert property (
      @(posedge clk_i) disable iff (srst_i)
      $changed(sysref_reg) && sysref_reg |-> $past(beat))
      else $error("Output rose off the beat.");
   cont_run_a: assert property (
      @(posedge clk_i) disable iff (srst_i)
      is_cont && $past(is_cont) && $past(cfg.busy) |-> cfg.busy)
      else $error("Continuous mode ended.");
   burst_c: cover property (@(posedge clk_i) state_reg == ST_DONE);
   cont_c: cover property (@(posedge clk_i)
      is_cont && sysref_reg ##1 !sysref_reg);
   level_c: cover property (@(posedge clk_i)
      is_level && state_reg == ST_RUN ##1 state_reg == ST_IDLE);
endmodule

// >>> core/srp_bank.sv
`timescale 1ns/1ps
// Operation
// - Mode 000: generator runs while a pulse request is held, and stops at the first low output after it drops.
// - Modes 001..101 burst 1,2,4,8,16 pulses; 110 also bursts 16.
// - Mode 111 toggles continuously at even duty until mode changes.
// - Retime bit set resamples sync input; clear passes it straight.
// - Polarity bit 0 positive, 1 inverts; software keeps it 0 normally.
// - Twelve-bit setpoint across two registers sets master beat rate.
// - Driver bit 0 enables output, bit 1 picks push-pull over drain.
// - Clock control bit 1 inserts divide-by-two on the clock path.
module srp_bank
(
   input wire logic CLK_I,              // 125 MHz clock
   input wire logic SRST_I,             // Synchronous reset
   input wire logic WR_EN_I,            // Host register write strobe
   input wire logic [7:0] ADDR_I,       // Host register address
   input wire logic [7:0] WDATA_I,      // Host write data
   output logic [7:0] RDATA_O,          // Host read data, registered
   input wire logic HOST_PULSE_REQ_I,   // Pulse request from host port
   input wire logic GENERAL_INPUT_PIN_I, // General input pin level
   input wire logic [2:0] GENERAL_INPUT_SEL_I, // Input pin function
   input wire logic SYNC_PIN_I,         // External sync input
   input wire logic SERIAL_DATA_I,      // Serial read data to drive out
   output logic SERIAL_DATA_OUT_PIN_O,  // Serial data pin output
   output logic SERIAL_DATA_OUT_PIN_OE_O, // Serial data pin enable
   output logic SYSREF_O,               // Reference pulse output
   output logic SYNC_EVENT_O,           // Sync event, polarity applied
   output logic CLK_DIV_EN_O,           // Divide-by-two clock enable
   output logic LOW_FREQ_BIAS_O,        // Low frequency input bias
   output logic DLY_LOW_POWER_O,        // Analog delay low power
   output logic BUSY_O                  // Generator running
);
   import srp_pkg::*;

   // ============================================================
   // Registers
   logic [7:0] drv_reg, pgen_reg, sync_reg, tlo_reg, thi_reg;
   logic [7:0] clk_reg, dly_reg, rdata_reg, rdata_next;
   logic [7:0] wd;
   assign wd = WDATA_I;

   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         drv_reg <= RST_SER_DRV;
         pgen_reg <= RST_PULSE_GEN;
         sync_reg <= RST_SYNC_IN;
         tlo_reg <= RST_TIMER_LO;
         thi_reg <= RST_TIMER_HI;
         clk_reg <= RST_CLK_IN;
         dly_reg <= RST_DLY_COMMON;
      end
      else if (WR_EN_I)
      begin
         unique case (ADDR_I)
            REG_SER_DRV: drv_reg <= wd & MASK_SER_DRV;
            REG_PULSE_GEN: pgen_reg <= wd & MASK_PULSE_GEN;
            REG_SYNC_IN: sync_reg <= wd & MASK_SYNC_IN;
            REG_TIMER_LO: tlo_reg <= wd;
            REG_TIMER_HI: thi_reg <= wd & MASK_TIMER_HI;
            REG_CLK_IN: clk_reg <= wd & MASK_CLK_IN;
            REG_DLY_COMMON: dly_reg <= wd & MASK_DLY_COMMON;
            default: ;
         endcase
      end
   end

   // Unmapped addresses read as zero.
   assign rdata_next = (ADDR_I == REG_SER_DRV) ? drv_reg :
                       (ADDR_I == REG_PULSE_GEN) ? pgen_reg :
                       (ADDR_I == REG_SYNC_IN) ? sync_reg :
                       (ADDR_I == REG_TIMER_LO) ? tlo_reg :
                       (ADDR_I == REG_TIMER_HI) ? thi_reg :
                       (ADDR_I == REG_CLK_IN) ? clk_reg :
                       (ADDR_I == REG_DLY_COMMON) ? dly_reg : 8'h00;
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rdata_next;
   end
   assign RDATA_O = rdata_reg;

   // ============================================================
   // Sync input path
   logic sync_pol, sync_retimed_reg, sync_sel;
   assign sync_pol = SYNC_PIN_I ^ sync_reg[SYNC_POL_BIT];
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
         sync_retimed_reg <= 1'b0;
      else
         sync_retimed_reg <= sync_pol;
   end
   // Bypass leaves the event unaligned to the clock, by intent.
   assign sync_sel = sync_reg[SYNC_RETIME_BIT] ? sync_retimed_reg
                                               : sync_pol;
   assign SYNC_EVENT_O = sync_sel;

   // ============================================================
   // Pulse request and engine
   logic gin_req, pulse_req;
   assign gin_req = GENERAL_INPUT_PIN_I
                    && (GENERAL_INPUT_SEL_I == GIN_SEL_PULSE);
   assign pulse_req = gin_req || HOST_PULSE_REQ_I || sync_sel;

   srp_cfg_if cfg ();
   assign cfg.mode = pgen_reg[2:0];
   assign cfg.setpoint = {thi_reg[3:0], tlo_reg};
   assign cfg.request = pulse_req;

   srp_pulse_engine u_engine
   (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .cfg(cfg)
   );
   assign SYSREF_O = cfg.sysref;
   assign BUSY_O = cfg.busy;

   // ============================================================
   // Serial data driver
   // Open-drain only pulls low; a high level comes from the pull-up.
   logic drv_on, drv_pp;
   assign drv_on = drv_reg[DRV_EN_BIT];
   assign drv_pp = drv_reg[DRV_PP_BIT];
   assign SERIAL_DATA_OUT_PIN_O = drv_pp ? SERIAL_DATA_I : 1'b0;
   assign SERIAL_DATA_OUT_PIN_OE_O = drv_on
                                     && (drv_pp || !SERIAL_DATA_I);

   // ============================================================
   // Clock input controls
   assign CLK_DIV_EN_O = clk_reg[CLK_DIV2_BIT];
   assign LOW_FREQ_BIAS_O = clk_reg[0];
   assign DLY_LOW_POWER_O = dly_reg[0];

   // ============================================================
   // Checks
   drv_off_a: assert property (
      @(posedge CLK_I) disable iff (SRST_I)
      !drv_reg[DRV_EN_BIT] |-> !SERIAL_DATA_OUT_PIN_OE_O)
      else $error("Driver enabled while off.");
   od_low_a: assert property (
      @(posedge CLK_I) disable iff (SRST_I)
      SERIAL_DATA_OUT_PIN_OE_O && !drv_reg[DRV_PP_BIT]
      |-> !SERIAL_DATA_OUT_PIN_O)
      else $error("Open drain drove high.");
   div2_a: assert property (
      @(posedge CLK_I) disable iff (SRST_I)
      WR_EN_I && ADDR_I == REG_CLK_IN
      |=> CLK_DIV_EN_O == $past(WDATA_I[1]))
      else $error("Divide select not taken.");
   retime_a: assert property (
      @(posedge CLK_I) disable iff (SRST_I)
      sync_reg[SYNC_RETIME_BIT] && $past(sync_reg[SYNC_RETIME_BIT])
      |-> SYNC_EVENT_O == $past(sync_pol))
      else $error("Retimed sync mismatch.");
   polarity_a: assert property (
      @(posedge CLK_I) disable iff (SRST_I)
      !sync_reg[SYNC_RETIME_BIT] |-> SYNC_EVENT_O ==
      (SYNC_PIN_I ^ sync_reg[SYNC_POL_BIT]))
      else $error("Sync polarity wrong.");
   wr_c: cover property (@(posedge CLK_I) WR_EN_I && ADDR_I == REG_TIMER_HI);
   drv_c: cover property (@(posedge CLK_I)
      SERIAL_DATA_OUT_PIN_OE_O && SERIAL_DATA_OUT_PIN_O);
endmodule

// >>> tb/srp_sysref_sink.sv
`timescale 1ns/1ps
// =====
// Far side: a converter that watches SYSREF, plus the pulled-up data line.
module srp_sysref_sink
(
   input wire logic clk_i,      // Sampling clock
   input wire logic sysref_i,   // Reference pulse from the device
   input wire logic serial_data_out_pin_i,    // Device data pin output
   input wire logic serial_data_out_pin_oe_i, // Device data pin enable
   output logic pin_o,          // Resolved data line level
   output int rises_o,          // Rising edges seen
   output int high_len_o,       // Cycles in the last high phase
   output int low_len_o         // Cycles in the last low phase
);
   logic last = 1'b0;
   int run = 0;
   int rises = 0;
   int high_len = 0;
   int low_len = 0;
   // A released open-drain line floats up to the pull-up level.
   assign pin_o = serial_data_out_pin_oe_i ? serial_data_out_pin_i : 1'b1;
   assign rises_o = rises;
   assign high_len_o = high_len;
   assign low_len_o = low_len;
   // Sampled on the falling edge, away from the device's launch edge.
   always @(negedge clk_i)
   begin
      if (sysref_i === last)
         run++;
      else
      begin
         if (last === 1'b1)
            high_len = run;
         else
            low_len = run;
         rises += (sysref_i === 1'b1);
         run = 1;
      end
      last = sysref_i;
   end
endmodule

// >>> tb/srp_bank_tb.sv
`timescale 1ns/1ps
module sysref_pulse_sync_control_tb;
   import srp_pkg::*;
   logic clk, rst, we, hreq, gpin, spin, sdi;
   logic [7:0] adr, wd;
   logic [2:0] gsel;
   wire logic [7:0] rd;
   wire logic sdo, sdoe, sref, sev, cdiv, lfb, dlp, busy, pin;
   int rises, hlen, llen, bad_count, check_count;
   srp_bank i_dut (.CLK_I(clk), .SRST_I(rst), .WR_EN_I(we), .ADDR_I(adr),
      .WDATA_I(wd), .RDATA_O(rd), .HOST_PULSE_REQ_I(hreq),
      .GENERAL_INPUT_PIN_I(gpin), .GENERAL_INPUT_SEL_I(gsel),
      .SYNC_PIN_I(spin), .SERIAL_DATA_I(sdi),
      .SERIAL_DATA_OUT_PIN_O(sdo), .SERIAL_DATA_OUT_PIN_OE_O(sdoe),
      .SYSREF_O(sref), .SYNC_EVENT_O(sev), .CLK_DIV_EN_O(cdiv),
      .LOW_FREQ_BIAS_O(lfb), .DLY_LOW_POWER_O(dlp), .BUSY_O(busy));
   srp_sysref_sink i_sink (.clk_i(clk), .sysref_i(sref), .serial_data_out_pin_i(sdo),
      .serial_data_out_pin_oe_i(sdoe), .pin_o(pin), .rises_o(rises),
      .high_len_o(hlen), .low_len_o(llen));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // =====
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      we = 1'b1;
      adr = a;
      wd = d;
      @(negedge clk);
      we = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      adr = a;
      @(negedge clk);
      chk(rd, exp);
   endtask
   // =====
   // Scenarios
   task automatic t_regs;
      logic [7:0] a [7];
      logic [7:0] m [7];
      a = '{REG_SER_DRV, REG_PULSE_GEN, REG_SYNC_IN, REG_TIMER_LO,
         REG_TIMER_HI, REG_CLK_IN, REG_DLY_COMMON};
      m = '{MASK_SER_DRV, MASK_PULSE_GEN, MASK_SYNC_IN, 8'hff,
         MASK_TIMER_HI, MASK_CLK_IN, MASK_DLY_COMMON};
      for (int i = 0; i < 7; i++)
      begin
         rdc(a[i], 8'h00);
         wr(a[i], 8'hff);
         rdc(a[i], m[i]);
         wr(a[i], 8'h00);
      end
      wr(8'h55, 8'hff);
      rdc(8'h55, 8'h00);
      $display("register test done");
   endtask
   task automatic t_burst;
      int n0;
      int k;
      logic [15:0] e;
      // A 32-cycle beat stays under 4 MHz at a 125 MHz clock.
      wr(REG_TIMER_LO, 8'h1f);
      wr(REG_TIMER_HI, 8'h00);
      for (int c = 1; c < 7; c++)
      begin
         e = (c == 6) ? 16'd16 : 16'(1 << (c - 1));
         wr(REG_PULSE_GEN, 8'(c));
         n0 = rises;
         hreq = 1'b1;
         cyc(3);
         for (k = 0; k < 2500 && busy !== 1'b0; k++) cyc(1);
         chk(busy, 1'b0);
         chk(16'(rises - n0), e);
         cyc(80);
         chk(16'(rises - n0), e);
         chk(sref, 1'b0);
         hreq = 1'b0;
      end
      $display("burst test done");
   endtask
   task automatic t_level;
      int n0;
      wr(REG_PULSE_GEN, 8'h00);
      // Host, input pin, input pin with another function, sync pin.
      for (int s = 0; s < 4; s++)
      begin
         n0 = rises;
         gsel = (s == 2) ? 3'h3 : GIN_SEL_PULSE;
         hreq = (s == 0);
         gpin = (s == 1 || s == 2);
         spin = (s == 3);
         cyc(200);
         chk(16'(rises - n0 >= 2), 16'(s != 2));
         hreq = 1'b0;
         gpin = 1'b0;
         spin = 1'b0;
         cyc(40);
         n0 = rises;
         cyc(60);
         chk(16'(rises - n0), 16'd0);
         chk(busy, 1'b0);
      end
      $display("level test done");
   endtask
   task automatic t_cont;
      int n0;
      logic [11:0] sp [2];
      sp = '{12'h01f, 12'h100};
      for (int i = 0; i < 2; i++)
      begin
         wr(REG_TIMER_LO, sp[i][7:0]);
         wr(REG_TIMER_HI, {4'h0, sp[i][11:8]});
         wr(REG_PULSE_GEN, 8'h07);
         cyc(6 * (sp[i] + 1) + 10);
         chk(16'(hlen), 16'(sp[i]) + 16'd1);
         chk(16'(llen), 16'(sp[i]) + 16'd1);
         wr(REG_PULSE_GEN, 8'h00);
         cyc(2 * (sp[i] + 1) + 4);
         n0 = rises;
         cyc(40);
         chk(16'(rises - n0), 16'd0);
      end
      $display("continuous test done");
   endtask
   task automatic t_sync;
      wr(REG_SYNC_IN, 8'h00);
      @(negedge clk);
      spin = 1'b1;
      #1 chk(sev, 1'b1);
      wr(REG_SYNC_IN, 8'h04);
      @(negedge clk);
      spin = 1'b0;
      #1 chk(sev, 1'b1);
      @(negedge clk);
      chk(sev, 1'b0);
      // Negative sense is set only briefly to see the inversion.
      wr(REG_SYNC_IN, 8'h01);
      cyc(1);
      chk(sev, 1'b1);
      wr(REG_SYNC_IN, 8'h00);
      $display("sync test done");
   endtask
   task automatic t_outs;
      for (int v = 0; v < 4; v++)
      begin
         wr(REG_SER_DRV, 8'(v));
         for (int d = 0; d < 2; d++)
         begin
            @(negedge clk);
            sdi = d[0];
            #1 chk(sdoe, v[0] & (v[1] | !d[0]));
            chk(pin, v[0] ? d[0] : 1'b1);
         end
      end
      wr(REG_CLK_IN, 8'h02);
      chk({cdiv, lfb}, 2'b10);
      wr(REG_CLK_IN, 8'h01);
      chk({cdiv, lfb}, 2'b01);
      wr(REG_DLY_COMMON, 8'h01);
      chk(dlp, 1'b1);
      $display("output control test done");
   endtask
   // =====
   // Main sequence and watchdog
   initial
   begin
      {rst, we, hreq, gpin, spin, sdi} = 6'b100000;
      {adr, wd, gsel} = 19'h0;
      bad_count = 0;
      check_count = 0;
      cyc(3);
      rst = 1'b0;
      t_regs;
      t_burst;
      t_level;
      t_cont;
      t_sync;
      t_outs;
      report_and_stop;
   end
   initial
   begin
      // The scenarios need about 8000 cycles; allow 20000.
      #160000;
      bad_count++;
      report_and_stop;
   end
endmodule
